// ===== hw/iso_in_circular_buffer_handshake.sv
// Isochronous IN ring buffer with ping-pong sample count handshake
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module iso_in_circular_buffer_handshake
  import iso_in_pkg::*;
#(
  parameter int AW            = 10,
  parameter int MARK_CYCLES   = MARK_SYS_CLKS,
  parameter int FRAME_CYCLES  = FRAME_SYS_CLKS,
  parameter int BYTES_PER_SMP = 2
) (
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  // Avalon-MM slave
  input  wire logic [5:0]    avs_address_in,
  input  wire logic          avs_read_in,
  input  wire logic          avs_write_in,
  input  wire logic [31:0]   avs_writedata_in,
  input  wire logic [3:0]    avs_byteenable_in,
  output logic [31:0]        avs_readdata_out,
  output logic               avs_waitrequest_out,
  // USB side events
  input  wire logic          sof_in,
  input  wire logic          frame_number_low_in,
  input  wire logic          in_token_in,
  // Codec DMA input stream
  input  wire logic          dma_valid_in,
  output logic               dma_ready_out,
  input  wire logic [7:0]    dma_data_in,
  input  wire logic          dma_frame_end_in,
  input  wire logic          dma_frame_busy_in,
  // Ring memory write port
  output logic               ring_we_out,
  output logic [AW-1:0]      ring_waddr_out,
  output logic [7:0]         ring_wdata_out,
  // Ring memory read port and packet output
  output logic               ring_re_out,
  output logic [AW-1:0]      ring_raddr_out,
  input  wire logic [7:0]    ring_rdata_in,
  output logic               pkt_valid_out,
  output logic [7:0]         pkt_data_out,
  output logic               pkt_last_out,
  output logic               pkt_zero_len_out,
  input  wire logic          pkt_ready_in,
  output logic               time_mark_out
);
  typedef enum logic [2:0] {
    DMA_IDLE = 3'b001,
    DMA_WAIT = 3'b010,
    DMA_PUB  = 3'b100
  } dma_state_t;

  typedef enum logic [3:0] {
    UBM_IDLE  = 4'b0001,
    UBM_READY = 4'b0010,
    UBM_SEND  = 4'b0100,
    UBM_DONE  = 4'b1000
  } ubm_state_t;

  logic [7:0]    count_first_r;
  logic [7:0]    count_second_r;
  logic [AW-1:0] base_r;
  logic [AW-1:0] size_r;
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic          run_r;
  logic [15:0]   sof_cnt_r;
  logic          mark_r;
  logic [CNT_W-1:0] tally_r;
  logic [7:0]    byte_in_smp_r;
  dma_state_t    dma_state_r;
  ubm_state_t    ubm_state_r;
  logic          sel_first_r;
  logic [CNT_W-1:0] target_r;
  logic [CNT_W-1:0] sent_smp_r;
  logic [7:0]    sent_byte_r;
  logic          init_req;
  logic          bus_wr;
  logic          bus_rd;
  logic          pub_first;
  logic          pub_fire;
  logic          free_first;
  logic          free_second;
  logic          fifo_in_valid;
  logic          fifo_in_ready;
  logic          fifo_in_last;
  logic [AW-1:0] wptr_nxt;
  logic [AW-1:0] rptr_nxt;
  logic          rd_pend_r;
  logic          rd_last_r;
  logic [CNT_W-1:0] tally_nxt;
  logic          rd_ack_r;
  logic          smp_done;

  function automatic logic [AW-1:0] ring_step(input logic [AW-1:0] p, input logic [AW-1:0] b,
                                               input logic [AW-1:0] s);
    if (p == b + s - {{(AW-1){1'b0}}, 1'b1}) begin
      ring_step = b;
    end else begin
      ring_step = p + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  assign bus_wr = avs_write_in && avs_address_in[5:4] == 2'b00;
  assign bus_rd = avs_read_in && !rd_ack_r;
  assign avs_waitrequest_out = bus_rd;
  assign init_req = bus_wr && avs_address_in[3:0] == REG_CTRL && avs_byteenable_in[0]
                    && avs_writedata_in[CTRL_INIT_BIT];

  // Register writes for control and ring geometry
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      run_r  <= 1'b0;
      base_r <= '0;
      size_r <= '1;
    end else if (bus_wr) begin
      unique case (avs_address_in[3:0])
        REG_CTRL: if (avs_byteenable_in[0]) begin
          run_r <= avs_writedata_in[CTRL_RUN_BIT];
        end
        REG_BASE: base_r <= avs_writedata_in[AW-1:0];
        REG_SIZE: size_r <= avs_writedata_in[AW-1:0];
        default: ;
      endcase
    end
  end

  // Reads wait one cycle so the loaded data stands when waitrequest drops
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= bus_rd;
    end
  end

  // Read data loaded in the wait cycle, held until the next read
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (bus_rd) begin
      avs_readdata_out <= 32'h0000_0000;
      if (avs_address_in[5:4] == 2'b00) begin
        unique case (avs_address_in[3:0])
          REG_CTRL:         avs_readdata_out <= {30'd0, 1'b0, run_r};
          REG_BASE:         avs_readdata_out <= {{(32-AW){1'b0}}, base_r};
          REG_SIZE:         avs_readdata_out <= {{(32-AW){1'b0}}, size_r};
          REG_COUNT_FIRST:  avs_readdata_out <= {24'd0, count_first_r};
          REG_COUNT_SECOND: avs_readdata_out <= {24'd0, count_second_r};
          REG_WPTR:         avs_readdata_out <= {{(32-AW){1'b0}}, wptr_r};
          REG_RPTR:         avs_readdata_out <= {{(32-AW){1'b0}}, rptr_r};
          REG_STATUS:       avs_readdata_out <= {25'd0, tally_r};
          default:          avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Frame timer: mark fires when MARK_CYCLES remain before next SOF
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || sof_in) begin
      sof_cnt_r <= '0;
      mark_r    <= 1'b0;
    end else begin
      if (sof_cnt_r != 16'(FRAME_CYCLES)) begin
        sof_cnt_r <= sof_cnt_r + 16'd1;
      end
      mark_r <= run_r && (sof_cnt_r == 16'(FRAME_CYCLES - MARK_CYCLES - 1));
    end
  end
  assign time_mark_out = mark_r;

  // Input bytes pass through a two-entry buffer towards the ring
  assign fifo_in_valid = dma_valid_in && run_r && dma_state_r != DMA_PUB;
  assign dma_ready_out = fifo_in_ready && run_r && dma_state_r != DMA_PUB;
  assign fifo_in_last  = dma_frame_end_in;

  logic          ring_v;
  logic [7:0]    ring_d;

  iso_skid_buf #(.W(8)) u_buf (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in || init_req),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (dma_data_in),
    .in_last_in    (fifo_in_last),
    .out_valid_out (ring_v),
    .out_ready_in  (1'b1),
    .out_data_out  (ring_d),
    .out_last_out  ()
  );

  // Buffer drains into the ring every cycle, one byte at a time
  assign ring_we_out    = ring_v;
  assign ring_waddr_out = wptr_r;
  assign ring_wdata_out = ring_d;
  assign wptr_nxt = ring_step(wptr_r, base_r, size_r);
  // Tally counts whole samples only
  assign smp_done  = ring_v && byte_in_smp_r == 8'(BYTES_PER_SMP - 1);
  assign tally_nxt = smp_done ? tally_r + 7'd1 : tally_r;

  // Write pointer and sample tally
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || init_req) begin
      wptr_r        <= base_r;
      tally_r       <= '0;
      byte_in_smp_r <= 8'd0;
    end else begin
      if (ring_v) begin
        wptr_r <= wptr_nxt;
        if (smp_done) begin
          byte_in_smp_r <= 8'd0;
        end else begin
          byte_in_smp_r <= byte_in_smp_r + 8'd1;
        end
      end
      tally_r <= pub_fire ? '0 : tally_nxt;
    end
  end

  // DMA publish sequencing
  assign pub_first = frame_number_low_in;
  // Publish waits until the last byte has left the buffer
  assign pub_fire  = dma_state_r == DMA_PUB && !ring_v;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || init_req || !run_r) begin
      dma_state_r <= DMA_IDLE;
    end else begin
      unique case (dma_state_r)
        DMA_IDLE: if (mark_r) begin
          dma_state_r <= DMA_WAIT;
        end
        DMA_WAIT: if (!dma_frame_busy_in || (dma_valid_in && dma_ready_out && dma_frame_end_in)) begin
          dma_state_r <= DMA_PUB;
        end
        DMA_PUB: if (!ring_v) begin
          dma_state_r <= DMA_IDLE;
        end
      endcase
    end
  end

  // Ping-pong count registers, publish wins over the release
  // Release the register that was just served
  assign free_first  = ubm_state_r == UBM_DONE && sel_first_r;
  assign free_second = ubm_state_r == UBM_DONE && !sel_first_r;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || init_req) begin
      count_first_r  <= COUNT_RESET;
      count_second_r <= COUNT_RESET;
    end else begin
      if (pub_fire && pub_first) begin
        count_first_r <= {1'b0, tally_r};
      end else if (free_first) begin
        count_first_r[CNT_NREADY_BIT] <= 1'b1;
      end
      if (pub_fire && !pub_first) begin
        count_second_r <= {1'b0, tally_r};
      end else if (free_second) begin
        count_second_r[CNT_NREADY_BIT] <= 1'b1;
      end
    end
  end

  // Buffer manager: serve IN transactions from the read pointer
  assign rptr_nxt = ring_step(rptr_r, base_r, size_r);
  assign ring_raddr_out = rptr_r;
  // New read only when the packet register is free or being emptied
  assign ring_re_out = ubm_state_r == UBM_SEND && !rd_pend_r && (!pkt_valid_out || pkt_ready_in);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || init_req) begin
      ubm_state_r <= UBM_IDLE;
      sel_first_r <= 1'b0;
      target_r    <= '0;
      sent_smp_r  <= '0;
      sent_byte_r <= 8'd0;
      rptr_r      <= base_r;
      rd_pend_r   <= 1'b0;
      rd_last_r   <= 1'b0;
    end else begin
      rd_pend_r <= ring_re_out;
      unique case (ubm_state_r)
        UBM_IDLE: if (sof_in) begin
          // Register seen ready at SOF is the one to serve
          if (!count_first_r[CNT_NREADY_BIT] && (count_second_r[CNT_NREADY_BIT] || !sel_first_r)) begin
            sel_first_r <= 1'b1;
            target_r    <= count_first_r[CNT_W-1:0];
            ubm_state_r <= UBM_READY;
          end else if (!count_second_r[CNT_NREADY_BIT]) begin
            sel_first_r <= 1'b0;
            target_r    <= count_second_r[CNT_W-1:0];
            ubm_state_r <= UBM_READY;
          end
        end
        UBM_READY: if (in_token_in) begin
          sent_smp_r  <= '0;
          sent_byte_r <= 8'd0;
          ubm_state_r <= (target_r == '0) ? UBM_DONE : UBM_SEND;
        end
        UBM_SEND: if (ring_re_out) begin
          rptr_r <= rptr_nxt;
          rd_last_r <= 1'b0;
          if (sent_byte_r == 8'(BYTES_PER_SMP - 1)) begin
            sent_byte_r <= 8'd0;
            sent_smp_r  <= sent_smp_r + 7'd1;
            if (sent_smp_r + 7'd1 == target_r) begin
              rd_last_r   <= 1'b1;
              ubm_state_r <= UBM_DONE;
            end
          end else begin
            sent_byte_r <= sent_byte_r + 8'd1;
          end
        end
        UBM_DONE: ubm_state_r <= UBM_IDLE;
      endcase
    end
  end

  // Packet output register, zero-length reply when nothing is ready
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || init_req) begin
      pkt_valid_out    <= 1'b0;
      pkt_data_out     <= 8'h00;
      pkt_last_out     <= 1'b0;
      pkt_zero_len_out <= 1'b0;
    end else begin
      pkt_zero_len_out <= in_token_in && count_first_r[CNT_NREADY_BIT]
                          && count_second_r[CNT_NREADY_BIT] && ubm_state_r != UBM_READY;
      if (rd_pend_r) begin
        pkt_valid_out <= 1'b1;
        pkt_data_out  <= ring_rdata_in;
        pkt_last_out  <= rd_last_r;
      end else if (pkt_ready_in) begin
        pkt_valid_out <= 1'b0;
        pkt_last_out  <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/iso_in_pkg.sv
// Constants for the isochronous IN circular buffer handshake
// Behaviour
// - Raise time mark when 1511 USB clock periods remain before next start-of-frame.
// - At time mark, finish current frame, then clear not-ready and load count.
// - Each count register holds not-ready flag and 7-bit sample count.
// - Frame number LSB 1 selects first count register, 0 selects second.
// - Init sets both pointers to base, not-ready flags to 1, counts to 0.
// - Write pointer advances per byte stored; running sample tally kept.
// - After publishing, tally resets to zero; publish repeats every time mark.
// - After flag clear and start-of-frame, serve IN from read pointer, per byte.
// - When published samples sent, set not-ready back to 1, end transaction.
// - Buffer manager alternates count registers on successive frames until halted.
// - IN token with both not-ready flags set gets a zero-length packet.
// - Ring uses programmed base address and programmed size as its length.
package iso_in_pkg;
  localparam logic [3:0] REG_CTRL        = 4'h0;
  localparam logic [3:0] REG_BASE        = 4'h1;
  localparam logic [3:0] REG_SIZE        = 4'h2;
  localparam logic [3:0] REG_COUNT_FIRST = 4'h3;
  localparam logic [3:0] REG_COUNT_SECOND= 4'h4;
  localparam logic [3:0] REG_WPTR        = 4'h5;
  localparam logic [3:0] REG_RPTR        = 4'h6;
  localparam logic [3:0] REG_STATUS      = 4'h7;
  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_INIT_BIT    = 1;
  localparam int CNT_NREADY_BIT   = 7;
  localparam int CNT_W            = 7;
  localparam logic [7:0] COUNT_RESET = 8'h80;
  localparam int USB_CLK_KHZ      = 12000;
  localparam int SYS_CLK_KHZ      = 20000;
  localparam int FRAME_USB_CLKS   = 12000;
  localparam int MARK_USB_CLKS    = 1511;
  localparam int MARK_SYS_CLKS    = (MARK_USB_CLKS * SYS_CLK_KHZ) / USB_CLK_KHZ;
  localparam int FRAME_SYS_CLKS   = (FRAME_USB_CLKS * SYS_CLK_KHZ) / USB_CLK_KHZ;
endpackage

// ===== hw/iso_skid_buf.sv
// Two-entry valid/ready buffer
`timescale 1ns/1ns
`default_nettype none
module iso_skid_buf #(
  parameter int W = 8
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  input  wire logic         in_last_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out,
  output logic              out_last_out
);
  logic [W:0] mem_r [2];
  logic       wr_r;
  logic       rd_r;
  logic [1:0] cnt_r;
  logic       push;
  logic       pop;

  assign in_ready_out  = (cnt_r != 2'd2);
  assign out_valid_out = (cnt_r != 2'd0);
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;
  assign out_data_out = mem_r[rd_r][W-1:0];
  assign out_last_out = mem_r[rd_r][W];

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_r[wr_r] <= {in_last_in, in_data_in};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_r  <= 1'b0;
      rd_r  <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      if (push) begin
        wr_r <= ~wr_r;
      end
      if (pop) begin
        rd_r <= ~rd_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ===== bench/iso_in_monitor.sv
// Concurrent checks on the ring buffer handshake ports
`timescale 1ns/1ns
`default_nettype none
module iso_in_monitor #(
  parameter int AW           = 10,
  parameter int MARK_CYCLES  = 2518,
  parameter int FRAME_CYCLES = 20000
) (
  input wire logic          sys_clk_in,
  input wire logic          rst_in,
  input wire logic          sof_in,
  input wire logic          in_token_in,
  input wire logic          ring_we_out,
  input wire logic [AW-1:0] ring_waddr_out,
  input wire logic          ring_re_out,
  input wire logic [AW-1:0] ring_raddr_out,
  input wire logic          pkt_valid_out,
  input wire logic [7:0]    pkt_data_out,
  input wire logic          pkt_last_out,
  input wire logic          pkt_zero_len_out,
  input wire logic          pkt_ready_in,
  input wire logic          time_mark_out
);
  logic [15:0]   since_sof_r;
  logic          sof_seen_r;
  logic          wr_seen_r;
  logic          rd_seen_r;
  logic [AW-1:0] last_waddr_r;
  logic [AW-1:0] last_raddr_r;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Cycles since the last start-of-frame
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sof_seen_r <= 1'b0;
      since_sof_r <= 16'h0000;
    end else if (sof_in) begin
      sof_seen_r <= 1'b1;
      since_sof_r <= 16'h0000;
    end else if (since_sof_r != 16'hFFFF) begin
      since_sof_r <= since_sof_r + 16'h0001;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_seen_r <= 1'b0;
    end else if (ring_we_out) begin
      wr_seen_r <= 1'b1;
      last_waddr_r <= ring_waddr_out;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_seen_r <= 1'b0;
    end else if (ring_re_out) begin
      rd_seen_r <= 1'b1;
      last_raddr_r <= ring_raddr_out;
    end
  end
  sequence s_stalled_beat;
    pkt_valid_out && !pkt_ready_in;
  endsequence
  sequence s_final_beat;
    pkt_valid_out && pkt_ready_in && pkt_last_out;
  endsequence
  property p_mark_offset;
    time_mark_out && sof_seen_r && since_sof_r < FRAME_CYCLES |-> since_sof_r == FRAME_CYCLES - MARK_CYCLES;
  endproperty
  property p_mark_pulse;
    time_mark_out |=> (!time_mark_out)[*8];
  endproperty
  property p_wr_step;
    ring_we_out && wr_seen_r |-> ring_waddr_out == last_waddr_r + 1'b1 || ring_waddr_out < last_waddr_r;
  endproperty
  property p_rd_step;
    ring_re_out && rd_seen_r |-> ring_raddr_out == last_raddr_r + 1'b1 || ring_raddr_out <= last_raddr_r;
  endproperty
  property p_re_feeds;
    ring_re_out |-> ##[1:60] pkt_valid_out;
  endproperty
  property p_zero_cause;
    pkt_zero_len_out |-> $past(in_token_in) && !pkt_valid_out;
  endproperty
  property p_pkt_hold;
    s_stalled_beat |=> pkt_valid_out && $stable(pkt_data_out) && $stable(pkt_last_out);
  endproperty
  property p_last_ends;
    s_final_beat |=> !pkt_valid_out && !pkt_zero_len_out;
  endproperty
  a_mark_offset: assert property (p_mark_offset)
    else $error("time mark off its offset from start of frame");
  a_mark_pulse: assert property (p_mark_pulse)
    else $error("time mark not a single pulse");
  a_wr_step: assert property (p_wr_step)
    else $error("ring write address skipped");
  a_rd_step: assert property (p_rd_step)
    else $error("ring read address skipped");
  a_re_feeds: assert property (p_re_feeds)
    else $error("ring read never reached the packet port");
  a_zero_cause: assert property (p_zero_cause)
    else $error("zero length reply without token or during data");
  a_pkt_hold: assert property (p_pkt_hold)
    else $error("packet byte changed while stalled");
  a_last_ends: assert property (p_last_ends)
    else $error("packet went on after last byte");
endmodule
bind iso_in_circular_buffer_handshake iso_in_monitor #(
  .AW(AW), .MARK_CYCLES(MARK_CYCLES), .FRAME_CYCLES(FRAME_CYCLES)
) u_mon (
  .sys_clk_in, .rst_in, .sof_in, .in_token_in, .ring_we_out, .ring_waddr_out, .ring_re_out, .ring_raddr_out,
  .pkt_valid_out, .pkt_data_out, .pkt_last_out, .pkt_zero_len_out, .pkt_ready_in, .time_mark_out
);
`default_nettype wire

// ===== bench/iso_ring_ram_model.sv
// Ring memory with one-cycle read latency
`timescale 1ns/1ns
`default_nettype none
module iso_ring_ram_model #(
  parameter int AW = 10
) (
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [7:0]    wdata_in,
  input  wire logic          re_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic [7:0]         rdata_out
);
  logic [7:0] mem_r [2**AW];
  always_ff @(posedge sys_clk_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end
  // Data only valid the cycle after a read; otherwise it toggles
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h5A;
    end else if (re_in) begin
      rdata_out <= mem_r[raddr_in];
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
endmodule
`default_nettype wire

// ===== bench/test_iso_in_circular_buffer_handshake.sv
// Testbench for the isochronous IN ring buffer handshake
`timescale 1ns/1ns
`default_nettype none
module test_iso_in_circular_buffer_handshake
  import iso_in_pkg::*;
;
  logic        sys_clk_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [5:0]  avs_address_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic        sof_in, frame_number_low_in, in_token_in, dma_valid_in, dma_ready_out;
  logic        dma_frame_end_in, dma_frame_busy_in, ring_we_out, ring_re_out, time_mark_out;
  logic [7:0]  dma_data_in, ring_wdata_out, ring_rdata_in, pkt_data_out, exp_q[$];
  logic [9:0]  ring_waddr_out, ring_raddr_out;
  logic        pkt_valid_out, pkt_last_out, pkt_zero_len_out, pkt_ready_in;
  int          n_mismatch, cmp_count;
  iso_in_circular_buffer_handshake #(.AW(10), .MARK_CYCLES(30), .FRAME_CYCLES(200), .BYTES_PER_SMP(2)) u_dut (
    .sys_clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .sof_in, .frame_number_low_in,
    .in_token_in, .dma_valid_in, .dma_ready_out, .dma_data_in, .dma_frame_end_in, .dma_frame_busy_in,
    .ring_we_out, .ring_waddr_out, .ring_wdata_out, .ring_re_out, .ring_raddr_out, .ring_rdata_in,
    .pkt_valid_out, .pkt_data_out, .pkt_last_out, .pkt_zero_len_out, .pkt_ready_in, .time_mark_out);
  iso_ring_ram_model #(.AW(10)) u_ram (.sys_clk_in, .rst_in, .we_in(ring_we_out), .waddr_in(ring_waddr_out),
    .wdata_in(ring_wdata_out), .re_in(ring_re_out), .raddr_in(ring_raddr_out), .rdata_out(ring_rdata_in));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    n_mismatch++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic wait_done(input int n, input int lim);
    if (n >= lim) bad("wait limit reached");
    if (n >= lim) tally_and_finish();
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) bad($sformatf("register %h expected %h", got, exp));
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) bad($sformatf("byte %h expected %h", got, exp));
  endtask
  // Request held until waitrequest is seen low; read data taken at that edge
  task automatic bus(input logic is_wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    avs_address_in <= {2'b00, a};
    avs_writedata_in <= wd;
    avs_write_in <= is_wr;
    avs_read_in <= !is_wr;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    rd = avs_readdata_out;
    wait_done(n, 50);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk_reg(x, e);
  endtask
  task automatic poll_pub(input logic [3:0] a);
    logic [31:0] x;
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0000_0000, x);
      n++;
    end while (x[CNT_NREADY_BIT] !== 1'b0 && n < 40);
    wait_done(n, 40);
  endtask
  task automatic pulse(input logic tok);
    @(posedge sys_clk_in);
    sof_in <= !tok;
    in_token_in <= tok;
    @(posedge sys_clk_in);
    sof_in <= 1'b0;
    in_token_in <= 1'b0;
  endtask
  task automatic wait_mark();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (time_mark_out !== 1'b1 && n < 400);
    wait_done(n, 400);
  endtask
  task automatic stream(input int nb, input logic [7:0] first);
    int k;
    int n;
    dma_frame_busy_in <= 1'b1;
    for (k = 0; k < nb; k++) begin
      dma_valid_in <= 1'b1;
      dma_data_in <= first + 8'(k);
      dma_frame_end_in <= (k == nb - 1);
      n = 0;
      do begin
        @(posedge sys_clk_in);
        n++;
      end while (dma_ready_out !== 1'b1 && n < 50);
      wait_done(n, 50);
      exp_q.push_back(first + 8'(k));
    end
    dma_valid_in <= 1'b0;
    dma_frame_end_in <= 1'b0;
    dma_frame_busy_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  // Receiver stalls every other cycle
  task automatic take_pkt(input int nb);
    int got;
    int n;
    got = 0;
    n = 0;
    pulse(1'b1);
    while (got < nb && n < 400) begin
      @(posedge sys_clk_in);
      n++;
      if (pkt_valid_out === 1'b1 && pkt_ready_in === 1'b1) begin
        chk_byte(pkt_data_out, exp_q.pop_front());
        chk_byte({7'b0, pkt_last_out}, {7'b0, got == nb - 1});
        got++;
      end
      pkt_ready_in <= ~pkt_ready_in;
    end
    wait_done(n, 400);
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    {rst_in, avs_read_in, avs_write_in, sof_in, frame_number_low_in, in_token_in} = 6'h01 << 5;
    {dma_valid_in, dma_frame_end_in, dma_frame_busy_in, pkt_ready_in} = 4'h1;
    {avs_address_in, avs_writedata_in, dma_data_in} = '0;
    avs_byteenable_in = 4'hF;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd_chk(REG_COUNT_FIRST, 32'h0000_0080);
    rd_chk(REG_COUNT_SECOND, 32'h0000_0080);
    rd_chk(REG_WPTR, 32'h0000_0000);
    rd_chk(4'h8, 32'h0000_0000);
    $display("test reset values done");
    wr(REG_BASE, 32'h0000_0100);
    wr(REG_SIZE, 32'h0000_0008);
    wr(REG_CTRL, 32'h0000_0003);
    rd_chk(REG_WPTR, 32'h0000_0100);
    rd_chk(REG_RPTR, 32'h0000_0100);
    pulse(1'b0);
    stream(6, 8'h10);
    rd_chk(REG_WPTR, 32'h0000_0106);
    rd_chk(REG_STATUS, 32'h0000_0003);
    frame_number_low_in <= 1'b1;
    wait_mark();
    poll_pub(REG_COUNT_FIRST);
    rd_chk(REG_COUNT_FIRST, 32'h0000_0003);
    rd_chk(REG_COUNT_SECOND, 32'h0000_0080);
    rd_chk(REG_STATUS, 32'h0000_0000);
    frame_number_low_in <= 1'b0;
    pulse(1'b0);
    take_pkt(6);
    rd_chk(REG_COUNT_FIRST, 32'h0000_0083);
    rd_chk(REG_RPTR, 32'h0000_0106);
    $display("test first frame done");
    dma_frame_busy_in <= 1'b1;
    wait_mark();
    rd_chk(REG_COUNT_SECOND, 32'h0000_0080);
    stream(4, 8'h40);
    poll_pub(REG_COUNT_SECOND);
    rd_chk(REG_COUNT_SECOND, 32'h0000_0002);
    rd_chk(REG_WPTR, 32'h0000_0102);
    pulse(1'b0);
    take_pkt(4);
    rd_chk(REG_COUNT_SECOND, 32'h0000_0082);
    rd_chk(REG_RPTR, 32'h0000_0102);
    pulse(1'b1);
    @(posedge sys_clk_in);
    chk_byte({7'b0, pkt_zero_len_out}, 8'h01);
    $display("test second frame done");
    avs_byteenable_in <= 4'hE;
    wr(REG_CTRL, 32'h0000_0000);
    avs_byteenable_in <= 4'hF;
    rd_chk(REG_CTRL, 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0003);
    rd_chk(REG_COUNT_SECOND, 32'h0000_0080);
    rd_chk(REG_RPTR, 32'h0000_0100);
    rd_chk(REG_WPTR, 32'h0000_0100);
    $display("test reinit done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
